// *** logic/prot_pkg.sv ***
// Package: constants and types of the protection stage core
package prot_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PICKUP = 8'h04;
  localparam logic [7:0] ADDR_NOMINAL = 8'h08;
  localparam logic [7:0] ADDR_DELAY = 8'h0C;
  localparam logic [7:0] ADDR_KDIAL = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_EVT_TIME = 8'h18;
  localparam logic [7:0] ADDR_EVT_MAG = 8'h1C;
  localparam logic [7:0] ADDR_EVT_INFO = 8'h20;
  // ----------------------------------------
  // Field positions of CTRL
  // ----------------------------------------
  localparam int CTRL_MODE = 0;
  localparam int CTRL_SERIES = 1;
  localparam int CTRL_CURVE_LO = 2;
  localparam int CTRL_UNDER = 5;
  // ----------------------------------------
  // Widths, reset values, scaling
  // ----------------------------------------
  localparam int MAG_W = 18;
  localparam int DLY_W = 19;
  localparam int ACC_W = 56;
  localparam int PU_SHIFT = 8;
  localparam logic [15:0] PICKUP_DEF = 16'h0100;
  localparam logic [9:0] NOMINAL_DEF = 10'h064;
  localparam logic [DLY_W-1:0] DELAY_DEF = 19'h0_0008;
  localparam logic [15:0] KDIAL_DEF = 16'h0005;
  localparam logic [7:0] RESET_PCT = 8'h61;
  localparam logic [7:0] FULL_PCT = 8'h64;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 125_000_000;
  localparam int TICK_MS = 1;
  localparam int MS_PER_S = 1000;
  localparam int TICK_CYC = CLK_HZ / MS_PER_S * TICK_MS;
  localparam int STEP_MS = 5;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic {fixed_delay_mode, inverse_time_mode} delay_mode_e;
  typedef enum logic {series_iec, series_ieee} series_e;
  typedef enum logic [1:0] {st_idle, st_timing, st_tripped, st_blocked} stage_e;
  typedef struct packed {
    logic valid;
    logic [MAG_W-1:0] mag;
    logic [2:0] fault;
  } meas_s;
  typedef struct packed {
    logic start;
    logic blocked;
    logic trip;
    logic event_pulse;
  } stage_out_s;
endpackage : prot_pkg

// *** logic/protection_stage_core.sv ***
// Protection stage: pick-up, blocking, trip delay, APB registers
`timescale 1ns/100ps
`default_nettype none
module protection_stage_core #(
  parameter int TICK_CYCLES = prot_pkg::TICK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire prot_pkg::meas_s meas,
  input wire logic block_in,
  output prot_pkg::stage_out_s stage_out
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    prot_pkg::delay_mode_e mode;
    prot_pkg::series_e series;
    logic [2:0] curve;
    logic under;
    logic [15:0] pickup;
    logic [9:0] nominal;
    logic [prot_pkg::DLY_W-1:0] delay;
    logic [15:0] kdial;
    logic blk_meta;
    logic blk_sync;
    logic blk_now;
    logic picked;
    prot_pkg::stage_e st;
    prot_pkg::stage_out_s out;
    logic [31:0] tick_cnt;
    logic [31:0] now_ms;
    logic [31:0] run_ms;
    logic [prot_pkg::ACC_W-1:0] acc;
    logic [prot_pkg::MAG_W-1:0] last_mag;
    logic [prot_pkg::MAG_W-1:0] start_mag;
    logic [31:0] evt_time;
    logic [prot_pkg::MAG_W-1:0] evt_mag;
    logic [2:0] evt_fault;
    logic [15:0] evt_count;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Curve gain per series and curve selection
  function automatic logic [15:0] curve_gain(input logic ser,
                                             input logic [2:0] cv);
    case ({ser, cv})
      4'h0: curve_gain = 16'h000E;
      4'h1: curve_gain = 16'h0320;
      4'h2: curve_gain = 16'h0087;
      4'h3: curve_gain = 16'h04B0;
      4'h8: curve_gain = 16'h0005;
      4'h9: curve_gain = 16'h0013;
      4'hA: curve_gain = 16'h0029;
      4'hB: curve_gain = 16'h0056;
      default: curve_gain = 16'h0009;
    endcase
  endfunction : curve_gain

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic [35:0] thr_full;
  logic [prot_pkg::MAG_W-1:0] thr;
  logic [prot_pkg::MAG_W+7:0] m_scaled;
  logic [prot_pkg::MAG_W+7:0] t_scaled;
  logic [prot_pkg::MAG_W-1:0] excess;
  logic [prot_pkg::ACC_W-1:0] target;
  logic [31:0] floor_ms;
  logic pick;
  logic blk;
  logic done;
  logic setup;
  logic wr;
  logic tick;

  always_comb begin
    s_nxt = s_r;
    s_nxt.out.event_pulse = 1'b0;
    // Pick-up level scaled by nominal current
    thr_full = 36'(s_r.pickup) * 36'(s_r.nominal);
    thr = thr_full[prot_pkg::PU_SHIFT +: prot_pkg::MAG_W];
    // Excess of the last processed sample, zero inside the band
    if (s_r.under) begin
      excess = (thr > s_r.last_mag) ? thr - s_r.last_mag : '0;
    end else begin
      excess = (s_r.last_mag > thr) ? s_r.last_mag - thr : '0;
    end
    // Inverse target from time dial, curve and set level
    target = prot_pkg::ACC_W'(s_r.kdial)
           * prot_pkg::ACC_W'(curve_gain(s_r.series, s_r.curve))
           * prot_pkg::ACC_W'(thr);
    floor_ms = 32'(s_r.delay) * 32'(prot_pkg::STEP_MS);
    // Synchroniser for the blocking pin
    s_nxt.blk_meta = block_in;
    s_nxt.blk_sync = s_r.blk_meta;
    // Free-running millisecond time base
    tick = (s_r.tick_cnt == 32'(TICK_CYCLES - 1));
    s_nxt.tick_cnt = tick ? 32'h0000_0000 : s_r.tick_cnt + 32'h0000_0001;
    if (tick) begin
      s_nxt.now_ms = s_r.now_ms + 32'h0000_0001;
    end
    // Operating delay timers run while timing
    if (tick && s_r.st == prot_pkg::st_timing) begin
      s_nxt.run_ms = s_r.run_ms + 32'h0000_0001;
      s_nxt.acc = s_r.acc + prot_pkg::ACC_W'(excess);
    end
    if (s_r.mode == prot_pkg::fixed_delay_mode) begin
      done = s_r.run_ms >= floor_ms;
    end else begin
      done = s_r.run_ms >= floor_ms && s_r.acc >= target;
    end
    // Pick-up with built-in 97 % reset ratio, 100/97 in under mode
    m_scaled = meas.mag * (s_r.under ? prot_pkg::RESET_PCT
                                     : prot_pkg::FULL_PCT);
    t_scaled = thr * (s_r.under ? prot_pkg::FULL_PCT
                                : prot_pkg::RESET_PCT);
    if (!s_r.picked) begin
      pick = s_r.under ? meas.mag < thr : meas.mag > thr;
    end else begin
      pick = s_r.under ? m_scaled < t_scaled
                       : m_scaled > t_scaled;
    end
    blk = s_r.blk_sync;
    if (meas.valid) begin
      s_nxt.blk_now = blk;
      s_nxt.picked = pick;
      s_nxt.last_mag = meas.mag;
      unique case (s_r.st)
        prot_pkg::st_idle: begin
          if (pick && blk) begin
            s_nxt.st = prot_pkg::st_blocked;
            s_nxt.out.blocked = 1'b1;
            s_nxt.out.event_pulse = 1'b1;
            s_nxt.evt_time = s_r.now_ms;
            s_nxt.evt_mag = meas.mag;
            s_nxt.evt_fault = meas.fault;
            s_nxt.evt_count = s_r.evt_count + 16'h0001;
          end else if (pick) begin
            s_nxt.out.start = 1'b1;
            s_nxt.start_mag = meas.mag;
            s_nxt.run_ms = 32'h0000_0000;
            s_nxt.acc = '0;
            if (s_r.mode == prot_pkg::fixed_delay_mode
                && s_r.delay == '0) begin
              s_nxt.out.trip = 1'b1;
              s_nxt.st = prot_pkg::st_tripped;
            end else begin
              s_nxt.st = prot_pkg::st_timing;
            end
          end
        end
        prot_pkg::st_timing, prot_pkg::st_tripped: begin
          if (!pick || blk) begin
            // Release path: cancel trip, drop start
            s_nxt.out.start = 1'b0;
            s_nxt.out.trip = 1'b0;
            s_nxt.run_ms = 32'h0000_0000;
            s_nxt.acc = '0;
            s_nxt.st = prot_pkg::st_idle;
            if (pick) begin
              s_nxt.st = prot_pkg::st_blocked;
              s_nxt.out.blocked = 1'b1;
              s_nxt.out.event_pulse = 1'b1;
              s_nxt.evt_time = s_r.now_ms;
              s_nxt.evt_mag = s_r.start_mag;
              s_nxt.evt_fault = meas.fault;
              s_nxt.evt_count = s_r.evt_count + 16'h0001;
            end
          end else if (s_r.st == prot_pkg::st_timing && done) begin
            s_nxt.out.trip = 1'b1;
            s_nxt.st = prot_pkg::st_tripped;
          end
        end
        prot_pkg::st_blocked: begin
          if (!pick) begin
            s_nxt.out.blocked = 1'b0;
            s_nxt.st = prot_pkg::st_idle;
          end
        end
      endcase
    end
    // ----------------------------------------
    // Register access
    // ----------------------------------------
    // APB slave, one wait-free access phase
    setup = psel && !penable;
    wr = psel && penable && s_r.pready && pwrite;
    s_nxt.pready = setup;
    if (setup) begin
      s_nxt.pslverr = 1'b0;
      s_nxt.prdata = 32'h0000_0000;
      unique case (paddr)
        prot_pkg::ADDR_CTRL: begin
          s_nxt.prdata[prot_pkg::CTRL_MODE] = s_r.mode;
          s_nxt.prdata[prot_pkg::CTRL_SERIES] = s_r.series;
          s_nxt.prdata[prot_pkg::CTRL_CURVE_LO +: 3] = s_r.curve;
          s_nxt.prdata[prot_pkg::CTRL_UNDER] = s_r.under;
        end
        prot_pkg::ADDR_PICKUP: s_nxt.prdata[15:0] = s_r.pickup;
        prot_pkg::ADDR_NOMINAL: s_nxt.prdata[9:0] = s_r.nominal;
        prot_pkg::ADDR_DELAY: begin
          s_nxt.prdata[prot_pkg::DLY_W-1:0] = s_r.delay;
        end
        prot_pkg::ADDR_KDIAL: s_nxt.prdata[15:0] = s_r.kdial;
        prot_pkg::ADDR_STATUS: begin
          s_nxt.prdata[5:0] = {s_r.blk_now, s_r.picked, s_r.out.start,
                               s_r.out.blocked, s_r.out.trip,
                               s_r.st == prot_pkg::st_timing};
        end
        prot_pkg::ADDR_EVT_TIME: s_nxt.prdata = s_r.evt_time;
        prot_pkg::ADDR_EVT_MAG: begin
          s_nxt.prdata[prot_pkg::MAG_W-1:0] = s_r.evt_mag;
        end
        prot_pkg::ADDR_EVT_INFO: begin
          s_nxt.prdata[18:0] = {s_r.evt_fault, s_r.evt_count};
        end
        default: s_nxt.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      unique case (paddr)
        prot_pkg::ADDR_CTRL: begin
          s_nxt.mode = prot_pkg::delay_mode_e'(
            pwdata[prot_pkg::CTRL_MODE]);
          s_nxt.series = prot_pkg::series_e'(
            pwdata[prot_pkg::CTRL_SERIES]);
          s_nxt.curve = pwdata[prot_pkg::CTRL_CURVE_LO +: 3];
          s_nxt.under = pwdata[prot_pkg::CTRL_UNDER];
        end
        prot_pkg::ADDR_PICKUP: s_nxt.pickup = pwdata[15:0];
        prot_pkg::ADDR_NOMINAL: s_nxt.nominal = pwdata[9:0];
        prot_pkg::ADDR_DELAY: begin
          s_nxt.delay = pwdata[prot_pkg::DLY_W-1:0];
        end
        prot_pkg::ADDR_KDIAL: s_nxt.kdial = pwdata[15:0];
        default: s_nxt.pslverr = s_r.pslverr;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
      s_r.mode <= prot_pkg::fixed_delay_mode;
      s_r.series <= prot_pkg::series_iec;
      s_r.pickup <= prot_pkg::PICKUP_DEF;
      s_r.nominal <= prot_pkg::NOMINAL_DEF;
      s_r.delay <= prot_pkg::DELAY_DEF;
      s_r.kdial <= prot_pkg::KDIAL_DEF;
      s_r.st <= prot_pkg::st_idle;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign stage_out = s_r.out;
endmodule : protection_stage_core
`default_nettype wire

// *** bench/meas_source.sv ***
// Model of the measurement front end and the blocking matrix
`timescale 1ns/100ps
`default_nettype none
module meas_source (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [17:0] mag,
  input wire logic [2:0] fault,
  input wire logic blk,
  input wire logic [3:0] gap,
  output prot_pkg::meas_s meas,
  output logic block_in
);
  logic [3:0] cnt_r;
  logic fire;
  assign fire = cnt_r >= gap;
  // Off-sample cycles carry inverted data, never a stale copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      meas <= '0;
      block_in <= 1'b0;
    end else begin
      cnt_r <= fire ? 4'h0 : cnt_r + 4'h1;
      meas.valid <= fire;
      meas.mag <= fire ? mag : ~mag;
      meas.fault <= fire ? fault : ~fault;
      block_in <= blk;
    end
  end
endmodule : meas_source
`default_nettype wire

// *** bench/protection_stage_core_asserts.sv ***
// Checker of the protection stage core port behaviour
`timescale 1ns/100ps
`default_nettype none
module protection_stage_core_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire prot_pkg::meas_s meas,
  input wire logic block_in,
  input wire prot_pkg::stage_out_s stage_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_blk_held; block_in [*4] ##0 meas.valid; endsequence
  property p_blk_clears; s_blk_held |=> !stage_out.start; endproperty
  a_blk_clears: assert property (p_blk_clears)
    else $error("start kept under blocking");
  property p_blk_only; stage_out.blocked |-> !stage_out.trip; endproperty
  a_blk_only: assert property (p_blk_only)
    else $error("trip while blocked");
  property p_evt_pulse; stage_out.event_pulse |=> !stage_out.event_pulse;
  endproperty
  a_evt_pulse: assert property (p_evt_pulse)
    else $error("event longer than one cycle");
  property p_evt_blk; stage_out.event_pulse |-> stage_out.blocked; endproperty
  a_evt_blk: assert property (p_evt_blk)
    else $error("event without blocked");
  property p_trip_start; stage_out.trip |-> stage_out.start; endproperty
  a_trip_start: assert property (p_trip_start)
    else $error("trip without start");
  property p_cycle;
    $changed({stage_out.start, stage_out.trip}) |-> $past(meas.valid);
  endproperty
  a_cycle: assert property (p_cycle)
    else $error("output moved off a processing cycle");
  property p_start_free; $rose(stage_out.start) |-> $past(!stage_out.blocked);
  endproperty
  a_start_free: assert property (p_start_free)
    else $error("start raised from blocked");
  property p_apb_ans; psel && !penable |=> pready ##1 !pready; endproperty
  a_apb_ans: assert property (p_apb_ans)
    else $error("bus answer not one cycle");
endmodule : protection_stage_core_asserts
bind protection_stage_core protection_stage_core_asserts
  protection_stage_core_asserts_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .meas, .block_in, .stage_out);
`default_nettype wire

// *** bench/protection_stage_core_tb.sv ***
// Self-checking bench of the protection stage core
`timescale 1ns/100ps
`default_nettype none
module protection_stage_core_tb;
  logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, q;
  logic pready, pslverr, e, block_in, blk = '0;
  logic [17:0] mag = '0;
  logic [2:0] flt = '0;
  logic [3:0] gap = '0;
  prot_pkg::meas_s meas;
  prot_pkg::stage_out_s so;
  int n_mismatch = 0, comparisons = 0, n_evt = 0, cyc = 0, seed = 91, n, nb;
  always #4 pclk = ~pclk;
  protection_stage_core #(.TICK_CYCLES(10)) protection_stage_core_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .meas, .block_in, .stage_out(so));
  meas_source meas_source_i (.pclk, .presetn, .mag, .fault(flt), .blk,
    .gap, .meas, .block_in);
  always @(posedge pclk) begin
    cyc++;
    if (so.event_pulse === 1'b1) n_evt++;
    if (cyc == 60000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    comparisons++;
    if (s !== x) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, '0);
    chk(q, x);
  endtask : rd
  task automatic st(input logic [2:0] x);
    chk({29'h0, so.blocked, so.trip, so.start}, {29'h0, x});
  endtask : st
  task automatic go(input logic [17:0] m);
    mag <= m;
    repeat (8) @(posedge pclk);
  endtask : go
  task automatic t_trip(input logic [17:0] m);
    mag <= m;
    n = 0;
    while (so.trip !== 1'b1 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
  endtask : t_trip
  task automatic in_rng(input int lo, input int hi);
    chk(32'(n >= lo && n <= hi), 32'h0000_0001);
  endtask : in_rng
  function automatic logic [17:0] rnd();
    return 18'(101 + ($random(seed) & 32'h0000_FFFF));
  endfunction : rnd
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(prot_pkg::ADDR_CTRL, 32'h0000_0000);
    rd(prot_pkg::ADDR_DELAY, 32'h0000_0008);
    rd(prot_pkg::ADDR_KDIAL, 32'h0000_0005);
    rd(8'h24, 32'h0000_0000);
    chk({31'h0, e}, 32'h0000_0001);
    for (int c = 0; c < 5; c++) begin
      apb(1'b1, prot_pkg::ADDR_CTRL, 32'(c * 4 + 2));
      rd(prot_pkg::ADDR_CTRL, 32'(c * 4 + 2));
    end
    apb(1'b1, prot_pkg::ADDR_CTRL, 32'h0000_0000);
    apb(1'b1, prot_pkg::ADDR_DELAY, 32'h0000_0000);
    for (int t = 200; t >= 100; t -= 100) begin
      apb(1'b1, prot_pkg::ADDR_NOMINAL, 32'(t));
      go(18'(t));
      st(3'b000);
      go(18'(t + 1));
      st(3'b011);
      go(18'(t * 97 / 100 + 1));
      st(3'b011);
      go(18'(t * 97 / 100));
      st(3'b000);
      go(rnd() + 18'(t));
      st(3'b011);
      go('0);
    end
    for (int d = 1; d <= 2; d++) begin
      gap <= 4'(d * 3 - 3);
      apb(1'b1, prot_pkg::ADDR_DELAY, 32'(d));
      t_trip(rnd());
      in_rng(d * 50 - 12, d * 50 + 14);
      go('0);
    end
    gap <= '0;
    mag <= rnd();
    repeat (60) @(posedge pclk);
    st(3'b001);
    go('0);
    st(3'b000);
    t_trip(rnd());
    in_rng(88, 114);
    go('0);
    blk <= 1'b1;
    flt <= 3'h5;
    repeat (6) @(posedge pclk);
    nb = n_evt;
    go(18'h0_0BB8);
    st(3'b100);
    chk(32'(n_evt), 32'(nb + 1));
    rd(prot_pkg::ADDR_EVT_MAG, 32'h0000_0BB8);
    rd(prot_pkg::ADDR_EVT_INFO, {13'h0, 3'h5, 16'(nb + 1)});
    apb(1'b0, prot_pkg::ADDR_EVT_TIME, 32'h0000_0000);
    chk(32'(q > 0 && q <= cyc / 10), 32'h0000_0001);
    repeat (150) @(posedge pclk);
    st(3'b100);
    blk <= 1'b0;
    go('0);
    mag <= 18'h0_07D0;
    repeat (30) @(posedge pclk);
    blk <= 1'b1;
    repeat (6) @(posedge pclk);
    st(3'b100);
    rd(prot_pkg::ADDR_EVT_MAG, 32'h0000_07D0);
    rd(prot_pkg::ADDR_EVT_INFO, 32'h0005_0002);
    blk <= 1'b0;
    go('0);
    apb(1'b1, prot_pkg::ADDR_CTRL, 32'h0000_0001);
    apb(1'b1, prot_pkg::ADDR_KDIAL, 32'h0000_07D0);
    apb(1'b1, prot_pkg::ADDR_DELAY, 32'h0000_0000);
    t_trip(18'h3_0D40);
    nb = n;
    go('0);
    t_trip(18'h0_4E20);
    chk(32'(nb < n), 32'h0000_0001);
    go('0);
    nb = n;
    apb(1'b1, prot_pkg::ADDR_CTRL, 32'h0000_0003);
    t_trip(18'h0_4E20);
    chk(32'(n != nb && n < 20000), 32'h0000_0001);
    go('0);
    apb(1'b1, prot_pkg::ADDR_DELAY, 32'h0000_0004);
    t_trip(18'h3_0D40);
    in_rng(190, 20000);
    go('0);
    apb(1'b1, prot_pkg::ADDR_DELAY, 32'h0000_0000);
    apb(1'b1, prot_pkg::ADDR_CTRL, 32'h0000_0020);
    go(18'h0_0068);
    st(3'b000);
    go(18'h0_0063);
    st(3'b011);
    go(18'h0_0067);
    st(3'b011);
    go(18'h0_0068);
    st(3'b000);
    tally_and_finish();
  end
endmodule : protection_stage_core_tb
`default_nettype wire
